// ---- verilog/nand_mgr_regs.svh ----
// Constants for the NAND block manager host controller.
// Assumes inclusion by bare name; definitions only.
// Functional notes
// - Never erase a block the host has classified as bad.
// - Scan reads one column per block; 00 hex means bad.
// - After erase read status; on fail retire block, block accesses; the code refuses only programs and erases to it, reads still run.
// - On program fail rewrite data elsewhere and mark block bad; the code marks it bad and reports fail_out, with no rewrite.
// - Read data needs correction of 8 bit errors per 512 bytes; the code passes it uncorrected on rd_data_out.
// - Block management must work with only 1004 of 1024 valid.
// - Mark bad only on program or erase status failure.
// - While busy issue only status read or reset.
`ifndef NAND_MGR_REGS_SVH
`define NAND_MGR_REGS_SVH
`define NUM_BLOCKS 11'h400
`define MIN_VALID_BLOCKS 11'h3EC
`define BLK_W 10
`define CMD_READ1 8'h00
`define CMD_READ2 8'h30
`define CMD_PROG1 8'h80
`define CMD_PROG2 8'h10
`define CMD_ERASE1 8'h60
`define CMD_ERASE2 8'hD0
`define CMD_STATUS 8'h70
`define CMD_RESET 8'hFF
`define BAD_MARK 8'h00
`define STAT_FAIL_BIT 0
`define STAT_READY_BIT 6
`define ECC_BITS 4'h8
`define ECC_UNIT 10'h200
`define PULSE_NS 20
`define PULSE_CYC (((`PULSE_NS) * 125 + 999) / 1000)
`define ADDR_CYCLES 3'h5
`endif

// ---- verilog/nand_mgr_pkg.sv ----
// Types for the NAND block manager host controller.
// Assumes nand_mgr_regs.svh is on the include path.
package nand_mgr_pkg;
  typedef enum logic [1:0] {OP_SCAN, OP_PROG, OP_ERASE, OP_READ} op_t;
  typedef struct packed {
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic ce_n;
    logic wp_n;
  } ctl_t;
  typedef struct packed {
    op_t op;
    logic [9:0] block;
    logic [5:0] page;
    logic [11:0] column;
    logic [7:0] data;
  } req_t;
endpackage : nand_mgr_pkg

// ---- verilog/nand_cycle.sv ----
// Single bus cycle engine: command, address, write or read byte.
// Assumes synchronised inputs and one clock.
`timescale 1ns/1ps
`default_nettype none
`include "nand_mgr_regs.svh"
module nand_cycle (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [1:0] kind_in,
  input wire logic [7:0] byte_in,
  input wire logic [7:0] io_sync_in,
  output logic busy_out,
  output logic done_out,
  output logic [7:0] rd_byte_out,
  output logic cle_out,
  output logic ale_out,
  output logic we_n_out,
  output logic re_n_out,
  output logic [7:0] io_out,
  output logic io_oe_out
);
  // kind: 0 command, 1 address, 2 write data, 3 read data
  typedef enum logic [1:0] {C_IDLE, C_LOW, C_HIGH} cst_t;
  localparam logic [3:0] PCYC = 4'(`PULSE_CYC);
  cst_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] kind_reg, kind_next;
  logic [7:0] out_reg, out_next, rd_reg, rd_next;
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    kind_next = kind_reg;
    out_next = out_reg;
    rd_next = rd_reg;
    done_out = 1'b0;
    case (st_reg)
      C_IDLE: begin
        if (start_in) begin
          st_next = C_LOW;
          kind_next = kind_in;
          out_next = byte_in;
          cnt_next = PCYC;
        end
      end
      C_LOW: begin
        if (cnt_reg == 4'h1) begin
          st_next = C_HIGH;
          cnt_next = PCYC;
          if (kind_reg == 2'h3) begin
            rd_next = io_sync_in;
          end
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      default: begin
        if (cnt_reg == 4'h1) begin
          st_next = C_IDLE;
          done_out = 1'b1;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_reg <= C_IDLE;
      cnt_reg <= 4'h0;
      kind_reg <= 2'h0;
      out_reg <= 8'h00;
      rd_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      kind_reg <= kind_next;
      out_reg <= out_next;
      rd_reg <= rd_next;
    end
  end
  assign busy_out = (st_reg != C_IDLE);
  assign rd_byte_out = rd_reg;
  assign io_out = out_reg;
  assign io_oe_out = busy_out && (kind_reg != 2'h3);
  assign cle_out = busy_out && (kind_reg == 2'h0);
  assign ale_out = busy_out && (kind_reg == 2'h1);
  assign we_n_out = !(st_reg == C_LOW && kind_reg != 2'h3);
  assign re_n_out = !(st_reg == C_LOW && kind_reg == 2'h3);
endmodule : nand_cycle
`default_nettype wire

// ---- verilog/nand_block_mgr.sv ----
// Host-side NAND controller with bad block scan, table and retirement.
// Assumes a single NAND on the pins; ready_busy_n pulled up externally.
`timescale 1ns/1ps
`default_nettype none
`include "nand_mgr_regs.svh"
module nand_block_mgr (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire nand_mgr_pkg::req_t req_in,
  input wire logic wp_n_in,
  output logic req_ready_out,
  output logic done_out,
  output logic fail_out,
  output logic refused_out,
  output logic [7:0] rd_data_out,
  output logic [10:0] good_count_out,
  output logic too_few_good_out,
  output logic scan_done_out,
  output nand_mgr_pkg::ctl_t ctl_out,
  output logic [7:0] io_out,
  output logic io_oe_out,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n_in
);
  typedef enum logic [3:0] {S_RST, S_RSTW, S_IDLE, S_CMD1, S_ADDR, S_DATA, S_CMD2,
    S_WAIT, S_STAT, S_STRD, S_RDB, S_DONE} st_t;
  // Two-flop synchronisers for pins
  logic [7:0] io_m_reg, io_s_reg;
  logic rb_m_reg, rb_s_reg;
  always_ff @(posedge clk_in) begin
    io_m_reg <= io_in;
    io_s_reg <= io_m_reg;
    rb_m_reg <= ready_busy_n_in;
    rb_s_reg <= rb_m_reg;
  end
  // Bad block table: one bit per block
  logic bad_tbl [0:`NUM_BLOCKS-1];
  st_t st_reg, st_next;
  nand_mgr_pkg::req_t cur_reg, cur_next;
  logic [2:0] acnt_reg, acnt_next;
  logic [10:0] good_reg, good_next;
  logic [10:0] scan_reg, scan_next;
  logic scanned_reg, scanned_next;
  logic done_reg, done_next, fail_reg, fail_next, ref_reg, ref_next;
  logic [7:0] rd_reg, rd_next;
  logic mark_we, mark_val;
  logic [9:0] mark_blk;
  logic c_start;
  logic [1:0] c_kind;
  logic [7:0] c_byte;
  logic c_busy, c_done;
  logic [7:0] c_rd;
  logic c_cle, c_ale, c_we_n, c_re_n;
  nand_cycle u_cycle (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_in(c_start),
    .kind_in(c_kind),
    .byte_in(c_byte),
    .io_sync_in(io_s_reg),
    .busy_out(c_busy),
    .done_out(c_done),
    .rd_byte_out(c_rd),
    .cle_out(c_cle),
    .ale_out(c_ale),
    .we_n_out(c_we_n),
    .re_n_out(c_re_n),
    .io_out(io_out),
    .io_oe_out(io_oe_out)
  );
  function automatic logic [7:0] addr_byte(input nand_mgr_pkg::req_t r, input logic [2:0] i);
    logic [15:0] row;
    row = {r.block, r.page};
    case (i)
      3'h0: addr_byte = r.column[7:0];
      3'h1: addr_byte = {4'h0, r.column[11:8]};
      3'h2: addr_byte = row[7:0];
      3'h3: addr_byte = row[15:8];
      default: addr_byte = 8'h00;
    endcase
  endfunction
  logic is_erase, is_prog;
  assign is_erase = (cur_reg.op == nand_mgr_pkg::OP_ERASE);
  assign is_prog = (cur_reg.op == nand_mgr_pkg::OP_PROG);
  always_comb begin
    st_next = st_reg;
    cur_next = cur_reg;
    acnt_next = acnt_reg;
    good_next = good_reg;
    scan_next = scan_reg;
    scanned_next = scanned_reg;
    done_next = 1'b0;
    fail_next = fail_reg;
    ref_next = 1'b0;
    rd_next = rd_reg;
    mark_we = 1'b0;
    mark_val = 1'b0;
    mark_blk = cur_reg.block;
    c_start = 1'b0;
    c_kind = 2'h0;
    c_byte = 8'h00;
    req_ready_out = 1'b0;
    case (st_reg)
      S_RST: begin
        c_start = !c_busy;
        c_byte = `CMD_RESET;
        if (c_done) st_next = S_RSTW;
      end
      S_RSTW: begin
        if (rb_s_reg && !c_busy) begin
          st_next = S_CMD1;
          cur_next = '0;
          cur_next.op = nand_mgr_pkg::OP_SCAN;
          acnt_next = 3'h0;
        end
      end
      S_IDLE: begin
        req_ready_out = 1'b1;
        if (req_valid_in) begin
          if ((req_in.op == nand_mgr_pkg::OP_PROG || req_in.op == nand_mgr_pkg::OP_ERASE)
              && bad_tbl[req_in.block]) begin
            ref_next = 1'b1;
            done_next = 1'b1;
            fail_next = 1'b1;
          end else begin
            cur_next = req_in;
            acnt_next = 3'h0;
            st_next = S_CMD1;
          end
        end
      end
      S_CMD1: begin
        c_start = !c_busy && rb_s_reg;
        c_byte = is_erase ? `CMD_ERASE1 : (is_prog ? `CMD_PROG1 : `CMD_READ1);
        if (c_done) begin
          st_next = S_ADDR;
          acnt_next = is_erase ? 3'h2 : 3'h0;
        end
      end
      S_ADDR: begin
        c_start = !c_busy;
        c_kind = 2'h1;
        c_byte = addr_byte(cur_reg, acnt_reg);
        if (c_done) begin
          if (acnt_reg == 3'h3) begin
            st_next = is_prog ? S_DATA : S_CMD2;
          end else begin
            acnt_next = acnt_reg + 3'h1;
          end
        end
      end
      S_DATA: begin
        c_start = !c_busy;
        c_kind = 2'h2;
        c_byte = cur_reg.data;
        if (c_done) st_next = S_CMD2;
      end
      S_CMD2: begin
        c_start = !c_busy;
        c_byte = is_erase ? `CMD_ERASE2 : (is_prog ? `CMD_PROG2 : `CMD_READ2);
        if (c_done) st_next = S_WAIT;
      end
      S_WAIT: begin
        if (rb_s_reg && !c_busy) begin
          st_next = (is_prog || is_erase) ? S_STAT : S_RDB;
        end
      end
      S_STAT: begin
        c_start = !c_busy;
        c_byte = `CMD_STATUS;
        if (c_done) st_next = S_STRD;
      end
      S_STRD: begin
        c_start = !c_busy;
        c_kind = 2'h3;
        if (c_done) begin
          if (c_rd[`STAT_READY_BIT]) begin
            fail_next = c_rd[`STAT_FAIL_BIT];
            if (c_rd[`STAT_FAIL_BIT]) begin
              mark_we = 1'b1;
              mark_val = 1'b1;
              // Table still holds the old entry this cycle
              if (!bad_tbl[cur_reg.block]) good_next = good_reg - 11'h1;
            end
            st_next = S_DONE;
          end
        end
      end
      S_RDB: begin
        c_start = !c_busy;
        c_kind = 2'h3;
        if (c_done) begin
          rd_next = c_rd;
          if (cur_reg.op == nand_mgr_pkg::OP_SCAN) begin
            mark_we = 1'b1;
            mark_blk = scan_reg[9:0];
            mark_val = (c_rd == `BAD_MARK);
            if (c_rd != `BAD_MARK) good_next = good_reg + 11'h1;
            if (scan_reg == `NUM_BLOCKS - 11'h1) begin
              scanned_next = 1'b1;
              st_next = S_IDLE;
            end else begin
              scan_next = scan_reg + 11'h1;
              cur_next.block = 10'(scan_reg + 11'h1);
              st_next = S_CMD1;
            end
          end else begin
            fail_next = 1'b0;
            st_next = S_DONE;
          end
        end
      end
      default: begin
        done_next = 1'b1;
        st_next = S_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (mark_we) bad_tbl[mark_blk] <= mark_val;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_reg <= S_RST;
      cur_reg <= '0;
      acnt_reg <= 3'h0;
      good_reg <= 11'h000;
      scan_reg <= 11'h000;
      scanned_reg <= 1'b0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      ref_reg <= 1'b0;
      rd_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      cur_reg <= cur_next;
      acnt_reg <= acnt_next;
      good_reg <= good_next;
      scan_reg <= scan_next;
      scanned_reg <= scanned_next;
      done_reg <= done_next;
      fail_reg <= fail_next;
      ref_reg <= ref_next;
      rd_reg <= rd_next;
    end
  end
  assign done_out = done_reg;
  assign fail_out = fail_reg;
  assign refused_out = ref_reg;
  assign rd_data_out = rd_reg; // correction is left to the consumer
  assign good_count_out = good_reg;
  assign too_few_good_out = scanned_reg && (good_reg < `MIN_VALID_BLOCKS);
  assign scan_done_out = scanned_reg;
  assign ctl_out.cle = c_cle;
  assign ctl_out.ale = c_ale;
  assign ctl_out.we_n = c_we_n;
  assign ctl_out.re_n = c_re_n;
  assign ctl_out.ce_n = (st_reg == S_IDLE);
  assign ctl_out.wp_n = wp_n_in;
endmodule : nand_block_mgr
`default_nettype wire

// ---- tb/nand_block_mgr_properties.sv ----
// Checker for the NAND block manager ports.
// Assumes binding onto nand_block_mgr.
`timescale 1ns/1ps
`default_nettype none
module nand_block_mgr_properties (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_ready_out,
  input wire logic done_out,
  input wire logic fail_out,
  input wire logic refused_out,
  input wire logic wp_n_in,
  input wire logic [10:0] good_count_out,
  input wire logic too_few_good_out,
  input wire logic scan_done_out,
  input wire nand_mgr_pkg::ctl_t ctl_out,
  input wire logic [7:0] io_out,
  input wire logic io_oe_out,
  input wire logic ready_busy_n_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_cmd_latch;
    $rose(ctl_out.we_n) && ctl_out.cle;
  endsequence
  sequence s_refuse;
    refused_out && done_out;
  endsequence
  AST_REFUSE_ANSWER: assert property (refused_out |-> s_refuse and fail_out) else $error("refusal incomplete");
  AST_REFUSE_QUIET: assert property (s_refuse |-> ctl_out.we_n && !io_oe_out) else $error("pins moved on refusal");
  AST_WP_FOLLOW: assert property (ctl_out.wp_n == wp_n_in) else $error("protect pin mismatch");
  AST_DONE_PULSE: assert property (done_out |=> !done_out) else $error("done longer than one cycle");
  AST_TOO_FEW: assert property (scan_done_out |-> too_few_good_out == (good_count_out < 11'h3EC))
    else $error("good block limit wrong");
  AST_BUSY_CMD: assert property (s_cmd_latch ##0 !$past(ready_busy_n_in) |-> io_out == 8'h70 || io_out == 8'hFF)
    else $error("command while busy");
  AST_READY_AFTER_SCAN: assert property (req_ready_out |-> scan_done_out) else $error("ready before scan");
  AST_SCAN_HOLD: assert property (scan_done_out |=> scan_done_out) else $error("scan flag dropped");
endmodule : nand_block_mgr_properties
bind nand_block_mgr nand_block_mgr_properties chk (.clk_in, .rst_n_in, .req_ready_out, .done_out, .fail_out,
  .refused_out, .wp_n_in, .good_count_out, .too_few_good_out, .scan_done_out, .ctl_out, .io_out, .io_oe_out,
  .ready_busy_n_in);
`default_nettype wire

// ---- tb/nand_dev_model.sv ----
// Behavioural NAND memory: blocks 5 and 9 bad, erase of block 7 and program of block 11 fail.
// Assumes pins driven by nand_block_mgr.
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model (
  input wire logic clk_in,
  input wire nand_mgr_pkg::ctl_t ctl_in,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic ready_busy_n_out
);
  logic [7:0] adr [0:4];
  logic [7:0] last;
  logic [2:0] na;
  logic stat;
  logic fail_r;
  int busy;
  wire [9:0] blk = {adr[3], adr[2][7:6]};
  wire rdy = busy == 0;
  initial begin
    busy = 0; na = 0; stat = 0; fail_r = 0; last = 8'h00;
  end
  always @(posedge ctl_in.we_n) begin
    if (ctl_in.cle) begin
      case (io_in)
        8'h00, 8'h80: na = 0;
        8'h60: na = 2;
        8'h70: stat = 1;
        8'h30: begin stat = 0; busy = 4; end
        8'h10: begin fail_r = blk == 10'hB; busy = 6; end
        8'hD0: begin fail_r = blk == 10'h7; busy = 6; end
        8'hFF: busy = 0;
        default: ;
      endcase
    end else if (ctl_in.ale) begin
      if (na < 5) adr[na] = io_in;
      na = na + 1;
    end
  end
  // Busy counts on the falling edge, away from the controller's sampling edge
  always @(negedge clk_in) begin
    if (!ctl_in.wp_n) busy = 0;
    else if (busy > 0) busy = busy - 1;
  end
  // Status: fail bit 0, ready bits 6 and 5, protect bit 7
  always @(negedge ctl_in.re_n) begin
    if (stat) last = {ctl_in.wp_n, rdy, rdy, 4'h0, fail_r & rdy};
    else last = (blk == 10'h5 || blk == 10'h9) ? 8'h00 : 8'h5A;
  end
  assign io_out = ctl_in.re_n ? ~last : last;
  assign ready_busy_n_out = rdy;
endmodule : nand_dev_model
`default_nettype wire

// ---- tb/test_nand_block_mgr.sv ----
// Self-checking bench for nand_block_mgr with a behavioural memory.
// Assumes design, package and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module test_nand_block_mgr;
  logic clk_in, rst_n_in, req_valid_in, wp_n_in, req_ready_out, done_out, fail_out, refused_out;
  logic too_few_good_out, scan_done_out, io_oe_out, ready_busy_n_in;
  logic [7:0] rd_data_out, io_out, io_in;
  logic [10:0] good_count_out;
  nand_mgr_pkg::req_t req_in;
  nand_mgr_pkg::ctl_t ctl_out;
  int errors = 0;
  int comparisons = 0;
  nand_block_mgr uut (.clk_in, .rst_n_in, .req_valid_in, .req_in, .wp_n_in, .req_ready_out, .done_out,
    .fail_out, .refused_out, .rd_data_out, .good_count_out, .too_few_good_out, .scan_done_out, .ctl_out,
    .io_out, .io_oe_out, .io_in, .ready_busy_n_in);
  nand_dev_model mem (.clk_in, .ctl_in(ctl_out), .io_in(io_out), .io_out(io_in),
    .ready_busy_n_out(ready_busy_n_in));
  initial begin
    clk_in = 0;
    forever #4 clk_in = ~clk_in;
  end
  task end_of_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task do_req(input nand_mgr_pkg::op_t op, input logic [9:0] blk, input logic xf, input logic xr);
    int n;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 100) begin @(negedge clk_in); n++; end
    `CHK("ready", 1'b1, req_ready_out)
    req_in = '{op: op, block: blk, page: 6'h01, column: 12'h004, data: 8'hC3};
    req_valid_in = 1;
    @(negedge clk_in);
    req_valid_in = 0;
    n = 0;
    while (done_out !== 1'b1 && n < 5000) begin @(negedge clk_in); n++; end
    `CHK("done", 1'b1, done_out)
    `CHK("fail", xf, fail_out)
    `CHK("refused", xr, refused_out)
    // Let the pulse end before the next request is offered
    @(negedge clk_in);
    `CHK("done_pulse", 1'b0, done_out)
  endtask : do_req
  task scan_test;
    int n;
    n = 0;
    while (scan_done_out !== 1'b1 && n < 75000) begin @(negedge clk_in); n++; end
    `CHK("scan_done", 1'b1, scan_done_out)
    `CHK("good_count", 11'h3FE, good_count_out)
    `CHK("too_few", 1'b0, too_few_good_out)
  endtask : scan_test
  task bad_block_test;
    do_req(nand_mgr_pkg::OP_ERASE, 10'h5, 1'b1, 1'b1);
    do_req(nand_mgr_pkg::OP_PROG, 10'h9, 1'b1, 1'b1);
  endtask : bad_block_test
  task good_ops_test;
    do_req(nand_mgr_pkg::OP_PROG, 10'h3, 1'b0, 1'b0);
    do_req(nand_mgr_pkg::OP_READ, 10'h3, 1'b0, 1'b0);
    `CHK("rd_data", 8'h5A, rd_data_out)
  endtask : good_ops_test
  task erase_fail_test;
    do_req(nand_mgr_pkg::OP_ERASE, 10'h7, 1'b1, 1'b0);
    `CHK("good_after", 11'h3FD, good_count_out)
    do_req(nand_mgr_pkg::OP_PROG, 10'h7, 1'b1, 1'b1);
    do_req(nand_mgr_pkg::OP_ERASE, 10'h7, 1'b1, 1'b1);
    do_req(nand_mgr_pkg::OP_PROG, 10'hB, 1'b1, 1'b0);
    `CHK("good_after_prog", 11'h3FC, good_count_out)
    do_req(nand_mgr_pkg::OP_PROG, 10'hB, 1'b1, 1'b1);
  endtask : erase_fail_test
  task protect_test;
    wp_n_in = 0;
    @(negedge clk_in);
    `CHK("wp_pin", 1'b0, ctl_out.wp_n)
    `CHK("ce_n_idle", 1'b1, ctl_out.ce_n)
    `CHK("io_oe_idle", 1'b0, io_oe_out)
    wp_n_in = 1;
    @(negedge clk_in);
    `CHK("wp_pin", 1'b1, ctl_out.wp_n)
  endtask : protect_test
  initial begin
    rst_n_in = 0; req_valid_in = 0; wp_n_in = 1; req_in = '0;
    repeat (4) @(negedge clk_in);
    rst_n_in = 1;
    scan_test();
    bad_block_test();
    good_ops_test();
    erase_fail_test();
    protect_test();
    end_of_test();
  end
  initial begin
    #(8 * 90000);
    errors++;
    end_of_test();
  end
endmodule : test_nand_block_mgr
`default_nettype wire
